// ===== shared/cwl_pkg.sv
package cwl_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [31:0] CWL_KEY_ADDR        = 32'h101c0070;
    localparam logic [31:0] CWL_STATUS_ADDR     = 32'h101c0074;
    localparam logic [31:0] CWL_CTRL_LO_ADDR    = 32'h101c0004;
    localparam logic [31:0] CWL_CTRL_HI_ADDR    = 32'h101c0038;
    localparam logic [31:0] CWL_PADMUX_LO_ADDR  = 32'h101c0a00;
    localparam logic [31:0] CWL_PADMUX_HI_ADDR  = 32'h101c0a5c;
    localparam logic [31:0] CWL_HOST_PAD_ADDR   = 32'h101c0c40;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int          CWL_KEY_W           = 16;
    localparam logic [15:0] CWL_KEY_RESET       = 16'h0000;
    localparam int          CWL_NUM_LOCKS       = 3;
    localparam logic [1:0]  CWL_MASTER_CORE     = 2'h0;
    localparam logic [1:0]  CWL_MASTER_AUX      = 2'h1;
    localparam logic [1:0]  CWL_MASTER_OTHER    = 2'h2;

    // ------------------------------------------------------------
    // per-master lock state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CWL_LOCKED,
        CWL_KEY_SEEN,
        CWL_UNLOCKED
    } cwl_lock_t;

endpackage : cwl_pkg

// ===== src/cwl_write_lock.sv
// Notes on behaviour
// - protected writes pass downstream only when the issuing master holds a valid key.
// - any access to a protected area invalidates that master's key.
// - core, auxiliary and other masters each keep an independent lock state.
// - key register 16-bit read/write, reset zero, upper sixteen bits read zero.
// - protected set: control block, 24 pad-matrix configs, host pad config.
`timescale 1ns/1ps
`default_nettype none

module cwl_write_lock
    import cwl_pkg::*;
(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              srst,
    // register port
    input  wire logic [31:0]       addr,
    input  wire logic [31:0]       wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    input  wire logic [1:0]        master_id,
    output logic      [31:0]       rdata,
    // guarded write towards protected registers
    output logic                   prot_wr,
    output logic      [31:0]       prot_addr,
    output logic      [31:0]       prot_wdata,
    output logic                   prot_blocked,
    // lock state per master
    output logic      [2:0]        unlocked
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0]   key;
        cwl_lock_t [2:0] lock;
        logic [31:0]   rdata;
        logic          prot_wr;
        logic [31:0]   prot_addr;
        logic [31:0]   prot_wdata;
        logic          prot_blocked;
        logic [2:0]    unlocked;
    } cwl_state_t;

    cwl_state_t st;
    cwl_state_t next_st;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic       in_ctrl;
    logic       in_padmux;
    logic       in_host;
    logic       in_prot;
    logic       key_hit;
    logic       status_hit;
    logic       key_match;

    always_comb begin
        // whole control block, gaps included, word aligned
        in_ctrl    = (addr >= CWL_CTRL_LO_ADDR)
                  && (addr <= CWL_CTRL_HI_ADDR)
                  && (addr[1:0] == 2'h0);
        // the twenty-four pad-matrix configuration words
        in_padmux  = (addr >= CWL_PADMUX_LO_ADDR)
                  && (addr <= CWL_PADMUX_HI_ADDR)
                  && (addr[1:0] == 2'h0);
        in_host    = (addr == CWL_HOST_PAD_ADDR);
        in_prot    = in_ctrl || in_padmux || in_host;
        key_hit    = (addr == CWL_KEY_ADDR);
        status_hit = (addr == CWL_STATUS_ADDR);
        key_match  = (wdata[CWL_KEY_W-1:0] == st.key);
    end

    // ------------------------------------------------------------
    // master select
    // ------------------------------------------------------------
    logic [1:0] inst;

    always_comb begin
        // anything not core or aux shares the third lock
        inst = (master_id == CWL_MASTER_CORE) ? CWL_MASTER_CORE :
               (master_id == CWL_MASTER_AUX)  ? CWL_MASTER_AUX  :
                                                CWL_MASTER_OTHER;
    end

    // ------------------------------------------------------------
    // lock instances
    // ------------------------------------------------------------
    logic      sel           [CWL_NUM_LOCKS];
    logic      ev_key_rd     [CWL_NUM_LOCKS];
    logic      ev_key_wr_ok  [CWL_NUM_LOCKS];
    logic      ev_key_wr_bad [CWL_NUM_LOCKS];
    logic      ev_prot       [CWL_NUM_LOCKS];
    logic      lock_open     [CWL_NUM_LOCKS];
    cwl_lock_t lock_upd      [CWL_NUM_LOCKS];

    // ------------------------------------------------------------
    // access classes
    // ------------------------------------------------------------
    logic       key_rd;
    logic       key_wr;
    logic       status_rd;
    logic       prot_access;
    logic       prot_wr_req;
    logic       grant;

    always_comb begin
        key_rd      = rd && key_hit;
        key_wr      = wr && key_hit;
        status_rd   = rd && status_hit;
        prot_access = (rd || wr) && in_prot;
        prot_wr_req = wr && in_prot;
        grant       = prot_wr_req && lock_open[inst];
    end

    for (genvar g = 0; g < CWL_NUM_LOCKS; g++) begin : g_lock
        // each lock only sees the accesses of its own masters
        assign sel[g]           = (inst == 2'(g));

        // a key read arms this lock
        assign ev_key_rd[g]     = sel[g] && key_rd;

        // the key written back unchanged after a read opens it
        assign ev_key_wr_ok[g]  = sel[g] && key_wr && key_match
                               && (st.lock[g] == CWL_KEY_SEEN);

        // any other key write closes it again
        assign ev_key_wr_bad[g] = sel[g] && key_wr && !ev_key_wr_ok[g];

        // any access to a protected word uses up the key
        assign ev_prot[g]       = sel[g] && prot_access;

        assign lock_open[g]     = (st.lock[g] == CWL_UNLOCKED);

        assign lock_upd[g]      = ev_key_wr_ok[g]  ? CWL_UNLOCKED :
                                  ev_key_wr_bad[g] ? CWL_LOCKED   :
                                  ev_prot[g]       ? CWL_LOCKED   :
                                  ev_key_rd[g]     ? CWL_KEY_SEEN :
                                                     st.lock[g];
    end : g_lock

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st              = st;
        next_st.rdata        = 32'h0000_0000;
        next_st.prot_wr      = 1'b0;
        next_st.prot_blocked = 1'b0;

        // ------------------------------------------------------------
        // read data, one cycle only
        // ------------------------------------------------------------
        if (key_rd) begin
            next_st.rdata = {16'h0000, st.key};
        end else if (status_rd) begin
            next_st.rdata = {29'h0000_0000, st.unlocked};
        end

        // ------------------------------------------------------------
        // key storage, upper half ignored
        // ------------------------------------------------------------
        if (key_wr) begin
            next_st.key = wdata[CWL_KEY_W-1:0];
        end

        // ------------------------------------------------------------
        // guarded write, out only with an open lock
        // ------------------------------------------------------------
        if (prot_wr_req) begin
            next_st.prot_addr  = addr;
            next_st.prot_wdata = wdata;
            if (grant) begin
                next_st.prot_wr = 1'b1;
            end else begin
                next_st.prot_blocked = 1'b1;
            end
        end

        // ------------------------------------------------------------
        // lock state
        // ------------------------------------------------------------
        for (int i = 0; i < CWL_NUM_LOCKS; i++) begin
            next_st.lock[i]     = lock_upd[i];
            next_st.unlocked[i] = (lock_upd[i] == CWL_UNLOCKED);
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            st.key          <= CWL_KEY_RESET;
            for (int i = 0; i < CWL_NUM_LOCKS; i++) begin
                st.lock[i] <= CWL_LOCKED;
            end
            st.rdata        <= 32'h0000_0000;
            st.prot_wr      <= 1'b0;
            st.prot_addr    <= 32'h0000_0000;
            st.prot_wdata   <= 32'h0000_0000;
            st.prot_blocked <= 1'b0;
            st.unlocked     <= 3'h0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rdata        = st.rdata;
    assign prot_wr      = st.prot_wr;
    assign prot_addr    = st.prot_addr;
    assign prot_wdata   = st.prot_wdata;
    assign prot_blocked = st.prot_blocked;
    assign unlocked     = st.unlocked;

endmodule : cwl_write_lock

`default_nettype wire

// ===== tb/cwl_write_lock_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cwl_write_lock_monitor import cwl_pkg::*; (
    input wire logic mclk, srst, wr, rd, prot_wr, prot_blocked,
    input wire logic [31:0] addr, rdata,
    input wire logic [1:0] master_id,
    input wire logic [2:0] unlocked
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    wire core_wr = wr && addr == CWL_CTRL_LO_ADDR && master_id == 2'h0;
    key_gate_a: assert property (wr && !unlocked |=> !prot_wr) else $error("gate");
    core_relock_a: assert property (core_wr |=> !unlocked[0]) else $error("relock");
    aux_kept_a: assert property (core_wr && unlocked[1] |=> unlocked[1])
        else $error("aux");
    key_upper_a: assert property (rd && addr == CWL_KEY_ADDR |=> !rdata[31:16])
        else $error("upper");
    pad_set_a: assert property (wr && addr==CWL_HOST_PAD_ADDR |=> prot_wr|prot_blocked)
        else $error("pad");
    drop_wr_a:
        assert property (wr && !unlocked && addr == CWL_CTRL_HI_ADDR |=> prot_blocked)
        else $error("drop");
endmodule : cwl_write_lock_monitor
bind cwl_write_lock cwl_write_lock_monitor cwl_write_lock_monitor_inst (.*);
`default_nettype wire

// ===== tb/cwl_prot_sink.sv
`timescale 1ns/1ps
`default_nettype none
module cwl_prot_sink (
    input wire logic mclk, prot_wr,
    input wire logic [31:0] prot_wdata,
    output logic [31:0] value
);
    always @(posedge mclk) if (prot_wr) value <= prot_wdata;
endmodule : cwl_prot_sink
`default_nettype wire

// ===== tb/cwl_write_lock_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
    $display("ERROR %0t %h %h", $time, a, b); end end
module cwl_write_lock_tb_top import cwl_pkg::*; ;
    logic mclk = 0, srst = 1, wr = 0, rd = 0, prot_wr, prot_blocked;
    logic [31:0] addr = 0, wdata = 0, rdata, prot_addr, prot_wdata, value;
    logic [1:0] master_id = 0; logic [2:0] unlocked; int err_total = 0, total_checks = 0;
    cwl_write_lock cwl_write_lock_inst (.*);
    cwl_prot_sink cwl_prot_sink_inst (.*);
    initial forever #10 mclk = ~mclk;
    task automatic acc(logic [1:0] m, logic [31:0] a, logic w, logic [31:0] d);
        @(posedge mclk);
        {master_id, addr, wdata, wr, rd} <= {m, a, d, w, !w};
        @(posedge mclk);
        {wr, rd} <= 2'h0;
        #1 if (!w) `CHK(rdata, d)
    endtask : acc
    task automatic unl(logic [1:0] m, logic [31:0] k);
        acc(m, CWL_KEY_ADDR, 0, k);
        acc(m, CWL_KEY_ADDR, 1, k);
    endtask : unl
    task automatic t_unlock;
        unl(2'h0, 32'h0);
        unl(2'h1, 32'h0);
        acc(2'h0, CWL_STATUS_ADDR, 0, 32'h3);
        acc(2'h0, CWL_CTRL_LO_ADDR, 1, 32'h5a);
        `CHK(prot_wr, 1'b1)
        `CHK(prot_addr, CWL_CTRL_LO_ADDR)
        acc(2'h1, CWL_HOST_PAD_ADDR, 1, 32'h3c);
        `CHK(prot_wdata, 32'h3c)
    endtask : t_unlock
    task automatic t_block;
        unl(2'h3, 32'h0);
        acc(2'h2, CWL_CTRL_HI_ADDR, 0, 32'h0);
        acc(2'h2, CWL_CTRL_HI_ADDR, 1, 32'h66);
        `CHK(prot_blocked, 1'b1)
        `CHK(prot_wr, 1'b0)
        unl(2'h2, 32'h0);
        `CHK(unlocked, 3'h4)
        `CHK(value, 32'h3c)
    endtask : t_block
    initial begin
        repeat (10) @(posedge mclk);
        srst <= 0;
        t_unlock;
        t_block;
        end_sim(0);
    end
    initial #20000 end_sim(1);
    task automatic end_sim(int extra);
        err_total += extra;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
endmodule : cwl_write_lock_tb_top
`default_nettype wire
